/* File: include/rtc_params.svh */
// constants for the remote tuning control block
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define RTC_CLK_MHZ 100
`define RTC_HOLD_MS 2000
`define RTC_HOLD_CYC (`RTC_HOLD_MS * `RTC_CLK_MHZ * 1000)
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RTC_OFF_CFG 8'h00
`define RTC_OFF_DMASK 8'h04
`define RTC_OFF_SEQ 8'h08
`define RTC_OFF_NOTE 8'h0C
`define RTC_OFF_DIV 8'h10
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RTC_F_PTOP 7:0
`define RTC_F_LTOP 15:8
`define RTC_F_NTOP 22:16
`define RTC_PTOP_RST 8'h08
`define RTC_LTOP_RST 8'h08
`define RTC_NTOP_RST 7'h3C
`define RTC_DMASK_RST 16'h0001
`define RTC_NOTE_LOW 7'h00
`define RTC_FIRST 8'h01
// ----------------------------------------
// button indices
// ----------------------------------------
`define RTC_B_PIST 0
`define RTC_B_REFN 1
`define RTC_B_REFD 3
`define RTC_B_SHIFT 5
`define RTC_B_UP 6
`define RTC_B_DN 7
`endif

/* File: include/rtc_pkg.sv */
// types for the remote tuning control block
package rtc_pkg;
    typedef enum logic [3:0] {
        RTC_CHROM = 4'h1,
        RTC_DIAT = 4'h2,
        RTC_TIERCE = 4'h4,
        RTC_OCTAVE = 4'h8
    } rtc_shift_t;
endpackage : rtc_pkg

/* File: core/rtc_core.sv */
// remote tuning control: buttons, piston sequencer, notes, divisions, axi4-lite registers
//
// Functional notes
// [R1] two notes, each own on/off and division
// [R2] piston button press toggles sequencing mode
// [R3] sequencing: up adds one to piston
// [R4] sequencing: down takes one from piston
// [R5] up at top piston: level up, piston 1
// [R6] down at piston 1: level down, top piston
// [R7] memory level wraps at both ends
// [R8] piston button held 2 s: both to 1
// [R9] note button press toggles note on/off
// [R10] up/down moves latched note by step
// [R11] both latched notes move together
// [R12] note button held: lowest C, note on
// [R13] division button press toggles division mode
// [R14] division mode: up/down steps division
// [R15] division order follows keying board address
// [R16] division button held: mode on, lowest division
// [R17] shift button cycles four step modes
// [R18] steps: 1, 2, 5, 12 semitones
// [R19] shift button held: back to chromatic
// [R20] release before 2 s is press
// [R21] notes saturate, divisions wrap
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_core import rtc_pkg::*; #(
    parameter int HOLD_CYCLES = `RTC_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic BTN_PISTON,
    input wire logic BTN_REF_NOTE,
    input wire logic BTN_TUNE_NOTE,
    input wire logic BTN_REF_DIV,
    input wire logic BTN_TUNE_DIV,
    input wire logic BTN_SHIFT,
    input wire logic BTN_UP,
    input wire logic BTN_DOWN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic SEQ_ACTIVE,
    output logic [7:0] GENERAL_PISTON,
    output logic [7:0] MEMORY_LEVEL_INDICATOR,
    output logic [1:0] NOTE_ON,
    output logic [6:0] REF_NOTE,
    output logic [6:0] TUNE_NOTE,
    output logic [1:0] DIV_MODE,
    output logic [3:0] REF_DIV,
    output logic [3:0] TUNE_DIV,
    output logic [3:0] SHIFT_MODE
);
    localparam logic [27:0] HOLD_M1 = 28'(HOLD_CYCLES - 1);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic rtc_shift_t shift_next(input rtc_shift_t m);
        unique case (m)
            RTC_CHROM: return RTC_DIAT;
            RTC_DIAT: return RTC_TIERCE;
            RTC_TIERCE: return RTC_OCTAVE;
            RTC_OCTAVE: return RTC_CHROM;
            default: return RTC_CHROM;
        endcase
    endfunction : shift_next

    function automatic logic [3:0] shift_step(input rtc_shift_t m);
        unique case (m)
            RTC_CHROM: return 4'h1;
            RTC_DIAT: return 4'h2;
            RTC_TIERCE: return 4'h5;
            RTC_OCTAVE: return 4'hC;
            default: return 4'h1;
        endcase
    endfunction : shift_step

    // saturating note move
    function automatic logic [6:0] note_move(input logic [6:0] cur, input logic [6:0] top,
                                             input logic [3:0] st, input logic up);
        logic [7:0] s;
        s = {1'b0, cur} + {4'h0, st};
        if (up) return (s > {1'b0, top}) ? top : s[6:0];
        return (cur < {3'h0, st}) ? `RTC_NOTE_LOW : cur - {3'h0, st};
    endfunction : note_move

    // next installed division in board address order, wrapping
    function automatic logic [3:0] div_next(input logic [3:0] cur, input logic [15:0] msk, input logic up);
        logic [3:0] c;
        logic [3:0] r;
        logic found;
        r = cur;
        found = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            c = up ? 4'(cur + 4'(i)) : 4'(cur - 4'(i));
            if (msk[c] && !found) begin
                r = c;
                found = 1'b1;
            end
        end
        return r;
    endfunction : div_next

    function automatic logic [3:0] div_low(input logic [15:0] msk);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (msk[i]) r = 4'(i);
        end
        return r;
    endfunction : div_low

    function automatic logic reg_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        return w == `RTC_OFF_CFG || w == `RTC_OFF_DMASK || w == `RTC_OFF_SEQ ||
               w == `RTC_OFF_NOTE || w == `RTC_OFF_DIV;
    endfunction : reg_mapped

    // ----------------------------------------
    // button synchronisers and press/hold detection
    // ----------------------------------------
    logic [7:0] btn_raw;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [5:0] press_ev;
    logic [5:0] hold_ev;
    logic up_ev;
    logic dn_ev;

    assign btn_raw = {BTN_DOWN, BTN_UP, BTN_SHIFT, BTN_TUNE_DIV, BTN_REF_DIV,
                      BTN_TUNE_NOTE, BTN_REF_NOTE, BTN_PISTON};

    // two flops per pin, then an edge history flop
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q <= 8'h00;
        end else begin
            sync1_q <= btn_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // up/down act on the press edge
    assign up_ev = sync2_q[`RTC_B_UP] && !prev_q[`RTC_B_UP];
    assign dn_ev = sync2_q[`RTC_B_DN] && !prev_q[`RTC_B_DN];

    // hold timer per button except up/down; a hold fires once, a short release is a press
    for (genvar g = 0; g < 6; g++) begin : g_hold
        logic [27:0] cnt_q;
        logic held_q;
        always_ff @(posedge CLK) begin
            if (!RST_N) begin
                cnt_q <= 28'h0000000;
                held_q <= 1'b0;
            end else if (!sync2_q[g]) begin
                cnt_q <= 28'h0000000;
                held_q <= 1'b0;
            end else if (!held_q) begin
                if (cnt_q == HOLD_M1) held_q <= 1'b1; // R20
                else cnt_q <= cnt_q + 28'h0000001;
            end
        end
        assign hold_ev[g] = sync2_q[g] && !held_q && cnt_q == HOLD_M1; // R20
        assign press_ev[g] = prev_q[g] && !sync2_q[g] && !held_q; // R20
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [22:0] cfg_q;
    logic [15:0] dmask_q;
    logic [7:0] ptop;
    logic [7:0] ltop;
    logic [6:0] ntop;

    assign ptop = cfg_q[`RTC_F_PTOP];
    assign ltop = cfg_q[`RTC_F_LTOP];
    assign ntop = cfg_q[`RTC_F_NTOP];

    // ----------------------------------------
    // general piston sequencer
    // ----------------------------------------
    logic seq_q;
    logic [7:0] piston_q;
    logic [7:0] level_q;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            seq_q <= 1'b0;
            piston_q <= `RTC_FIRST;
            level_q <= `RTC_FIRST;
        end else begin
            if (press_ev[`RTC_B_PIST]) seq_q <= !seq_q; // R2
            if (hold_ev[`RTC_B_PIST]) begin
                piston_q <= `RTC_FIRST; // R8
                level_q <= `RTC_FIRST; // R8
            end else if (seq_q && up_ev) begin
                if (piston_q >= ptop) begin
                    piston_q <= `RTC_FIRST; // R5
                    level_q <= (level_q >= ltop) ? `RTC_FIRST : level_q + 8'h01; // R5 R7
                end else begin
                    piston_q <= piston_q + 8'h01; // R3
                end
            end else if (seq_q && dn_ev) begin
                if (piston_q <= `RTC_FIRST) begin
                    piston_q <= ptop; // R6
                    level_q <= (level_q <= `RTC_FIRST) ? ltop : level_q - 8'h01; // R6 R7
                end else begin
                    piston_q <= piston_q - 8'h01; // R4
                end
            end
        end
    end

    // ----------------------------------------
    // shift mode
    // ----------------------------------------
    rtc_shift_t shift_q;
    logic [3:0] step;

    assign step = shift_step(shift_q); // R18

    always_ff @(posedge CLK) begin
        if (!RST_N) shift_q <= RTC_CHROM;
        else if (hold_ev[`RTC_B_SHIFT]) shift_q <= RTC_CHROM; // R19
        else if (press_ev[`RTC_B_SHIFT]) shift_q <= shift_next(shift_q); // R17
    end

    // ----------------------------------------
    // reference (0) and tuning (1) notes
    // ----------------------------------------
    logic [1:0] on_q;
    logic [6:0] note_q [2];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            on_q <= 2'b00;
            note_q[0] <= `RTC_NOTE_LOW;
            note_q[1] <= `RTC_NOTE_LOW;
        end else begin
            for (int n = 0; n < 2; n++) begin // R1
                if (hold_ev[`RTC_B_REFN + n]) begin
                    note_q[n] <= `RTC_NOTE_LOW; // R12
                    on_q[n] <= 1'b1; // R12
                end else begin
                    if (press_ev[`RTC_B_REFN + n]) on_q[n] <= !on_q[n]; // R9
                    // every latched note takes the same step
                    if (on_q[n] && (up_ev || dn_ev)) note_q[n] <= note_move(note_q[n], ntop, step, up_ev); // R10 R11 R21
                end
            end
        end
    end

    // ----------------------------------------
    // division selection per note
    // ----------------------------------------
    logic [1:0] dmode_q;
    logic [3:0] div_q [2];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dmode_q <= 2'b00;
            div_q[0] <= 4'h0;
            div_q[1] <= 4'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin // R1
                if (hold_ev[`RTC_B_REFD + n]) begin
                    dmode_q[n] <= 1'b1; // R16
                    div_q[n] <= div_low(dmask_q); // R16 R15
                end else begin
                    if (press_ev[`RTC_B_REFD + n]) dmode_q[n] <= !dmode_q[n]; // R13
                    if (dmode_q[n] && (up_ev || dn_ev)) div_q[n] <= div_next(div_q[n], dmask_q, up_ev); // R14 R15 R21
                end
            end
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic awready_q, wready_q, bvalid_q, aw_got_q, w_got_q;
    logic arready_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic aw_take, w_take, do_wr, aw_got_d, w_got_d, bvalid_d;
    logic [31:0] cfg_new, dmask_new;

    assign aw_take = awready_q && S_AXI_AWVALID;
    assign w_take = wready_q && S_AXI_WVALID;
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;
    assign aw_got_d = (aw_got_q || aw_take) && !do_wr;
    assign w_got_d = (w_got_q || w_take) && !do_wr;
    assign bvalid_d = do_wr || (bvalid_q && !S_AXI_BREADY);

    // byte lane merge of write data onto the old contents
    always_comb begin
        cfg_new = {9'h000, cfg_q};
        dmask_new = {16'h0000, dmask_q};
        for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) cfg_new[b*8 +: 8] = wdata_q[b*8 +: 8];
            if (wstrb_q[b]) dmask_new[b*8 +: 8] = wdata_q[b*8 +: 8];
        end
    end

    // write channels taken in either order, response after both
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            bvalid_q <= bvalid_d;
            awready_q <= !aw_got_d && !bvalid_d;
            wready_q <= !w_got_d && !bvalid_d;
            if (aw_take) awaddr_q <= S_AXI_AWADDR;
            if (w_take) wdata_q <= S_AXI_WDATA;
            if (w_take) wstrb_q <= S_AXI_WSTRB;
            if (do_wr) bresp_q <= reg_mapped(awaddr_q) ? 2'b00 : 2'b10;
        end
    end

    // writable registers; status offsets ignore writes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_q <= {`RTC_NTOP_RST, `RTC_LTOP_RST, `RTC_PTOP_RST};
            dmask_q <= `RTC_DMASK_RST;
        end else if (do_wr) begin
            if ({awaddr_q[7:2], 2'b00} == `RTC_OFF_CFG) cfg_q <= cfg_new[22:0];
            if ({awaddr_q[7:2], 2'b00} == `RTC_OFF_DMASK) dmask_q <= dmask_new[15:0];
        end
    end

    // read: one address at a time, data latched at the address edge
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
        end else if (arready_q && S_AXI_ARVALID) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= reg_mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
            unique case ({S_AXI_ARADDR[7:2], 2'b00})
                `RTC_OFF_CFG: rdata_q <= {9'h000, cfg_q};
                `RTC_OFF_DMASK: rdata_q <= {16'h0000, dmask_q};
                `RTC_OFF_SEQ: rdata_q <= {11'h000, shift_q, seq_q, level_q, piston_q};
                `RTC_OFF_NOTE: rdata_q <= {12'h000, dmode_q, on_q, 1'b0, note_q[1], 1'b0, note_q[0]};
                `RTC_OFF_DIV: rdata_q <= {20'h00000, div_q[1], 4'h0, div_q[0]};
                default: rdata_q <= 32'h00000000;
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign SEQ_ACTIVE = seq_q;
    assign GENERAL_PISTON = piston_q;
    assign MEMORY_LEVEL_INDICATOR = level_q;
    assign NOTE_ON = on_q;
    assign REF_NOTE = note_q[0];
    assign TUNE_NOTE = note_q[1];
    assign DIV_MODE = dmode_q;
    assign REF_DIV = div_q[0];
    assign TUNE_DIV = div_q[1];
    assign SHIFT_MODE = shift_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_seq_toggle;
        press_ev[`RTC_B_PIST] |=> seq_q != $past(seq_q);
    endproperty
    a_seq_toggle: assert property (p_seq_toggle) else $error("sequencer mode did not toggle"); // R2

    property p_pist_up;
        seq_q && up_ev && !hold_ev[`RTC_B_PIST] && piston_q < ptop |=> piston_q == $past(piston_q) + 8'h01;
    endproperty
    a_pist_up: assert property (p_pist_up) else $error("piston did not step up"); // R3

    property p_pist_dn;
        seq_q && !up_ev && dn_ev && !hold_ev[`RTC_B_PIST] && piston_q > `RTC_FIRST
            |=> piston_q == $past(piston_q) - 8'h01 && level_q == $past(level_q);
    endproperty
    a_pist_dn: assert property (p_pist_dn) else $error("piston did not step down"); // R4

    property p_wrap_up;
        seq_q && up_ev && !hold_ev[`RTC_B_PIST] && piston_q == ptop && level_q == ltop
            |=> piston_q == `RTC_FIRST && level_q == `RTC_FIRST;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("top piston and level did not wrap"); // R5 R7

    property p_wrap_dn;
        seq_q && !up_ev && dn_ev && !hold_ev[`RTC_B_PIST] && piston_q == `RTC_FIRST && level_q == `RTC_FIRST
            |=> piston_q == $past(ptop) && level_q == $past(ltop);
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("lowest piston and level did not wrap"); // R6 R7

    property p_pist_hold;
        hold_ev[`RTC_B_PIST] |=> piston_q == `RTC_FIRST && level_q == `RTC_FIRST;
    endproperty
    a_pist_hold: assert property (p_pist_hold) else $error("piston hold did not reset"); // R8

    property p_note_toggle;
        press_ev[`RTC_B_REFN] |=> on_q[0] != $past(on_q[0]);
    endproperty
    a_note_toggle: assert property (p_note_toggle) else $error("note did not toggle"); // R9

    property p_note_pair;
        on_q == 2'b11 && up_ev && hold_ev[2:1] == 2'b00 && note_q[0] == note_q[1] |=> note_q[0] == note_q[1];
    endproperty
    a_note_pair: assert property (p_note_pair) else $error("latched notes moved apart"); // R11 R10

    property p_note_hold;
        hold_ev[`RTC_B_REFN] |=> on_q[0] && note_q[0] == `RTC_NOTE_LOW;
    endproperty
    a_note_hold: assert property (p_note_hold) else $error("note hold did not reset"); // R12

    property p_note_sat;
        on_q[0] && up_ev && !hold_ev[`RTC_B_REFN] && note_q[0] == ntop |=> note_q[0] == $past(ntop);
    endproperty
    a_note_sat: assert property (p_note_sat) else $error("note passed top of range"); // R21

    property p_shift_cycle;
        shift_q == RTC_OCTAVE && press_ev[`RTC_B_SHIFT] |=> shift_q == RTC_CHROM && step == 4'h1;
    endproperty
    a_shift_cycle: assert property (p_shift_cycle) else $error("shift mode did not cycle"); // R17 R18

    property p_div_hold;
        hold_ev[`RTC_B_REFD] |=> dmode_q[0] && div_q[0] == div_low(dmask_q);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("division hold did not reset"); // R16

    property p_hold_len;
        $rose(sync2_q[`RTC_B_SHIFT]) |-> !hold_ev[`RTC_B_SHIFT] [*2];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold fired too early"); // R20

    c_pist_wrap: cover property (seq_q && up_ev && piston_q == ptop);
    c_both_notes: cover property (on_q == 2'b11 && dn_ev);
    c_div_step: cover property (dmode_q[1] && up_ev);
    c_axi_write: cover property (do_wr && bresp_q == 2'b00);
endmodule : rtc_core

/* File: verification/rtc_remote.sv */
// hand-held remote model driving the button pins
`timescale 1ns/1ns
module rtc_remote (
    input wire logic CLK,
    output logic [7:0] btn
);
    // buttons rest released (low) from time zero
    initial btn = 8'h00;

    // press one button for n cycles, release, then let the result settle
    task automatic push(input int i, input int n);
        @(posedge CLK);
        btn[i] <= 1'b1;
        repeat (n) @(posedge CLK);
        btn[i] <= 1'b0;
        repeat (8) @(posedge CLK);
    endtask : push
endmodule : rtc_remote

/* File: verification/remote_tuning_control_bench.sv */
// self-checking bench for the remote tuning control block
`timescale 1ns/1ns
module remote_tuning_control_bench;
    import rtc_pkg::*;
    localparam int HOLD = 20;
    localparam int TAP = 4;
    localparam int LONG = HOLD + 8;
    localparam int PST = 0, RFN = 1, TNN = 2, RFD = 3, TND = 4, SHF = 5, UP = 6, DN = 7;
    logic CLK = 1'b0, RST_N = 1'b0;
    logic [7:0] btn;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, seq;
    logic [7:0] pist, lvl;
    logic [1:0] non, dmode;
    logic [6:0] rn, tn;
    logic [3:0] rd, td, sm;
    int n_errors = 0, n_checks = 0;
    int p, l, ref_n;
    logic [3:0] oh [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    int stp [4] = '{1, 2, 5, 12};

    always #5 CLK = ~CLK;

    rtc_remote rem (.CLK(CLK), .btn(btn));

    rtc_core #(.HOLD_CYCLES(HOLD)) uut (
        .CLK(CLK), .RST_N(RST_N), .BTN_PISTON(btn[PST]), .BTN_REF_NOTE(btn[RFN]),
        .BTN_TUNE_NOTE(btn[TNN]), .BTN_REF_DIV(btn[RFD]), .BTN_TUNE_DIV(btn[TND]),
        .BTN_SHIFT(btn[SHF]), .BTN_UP(btn[UP]), .BTN_DOWN(btn[DN]),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SEQ_ACTIVE(seq), .GENERAL_PISTON(pist), .MEMORY_LEVEL_INDICATOR(lvl), .NOTE_ON(non),
        .REF_NOTE(rn), .TUNE_NOTE(tn), .DIV_MODE(dmode), .REF_DIV(rd), .TUNE_DIV(td),
        .SHIFT_MODE(sm)
    );

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // axi4-lite write: address and data offered together, held until taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge CLK);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge CLK); while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask : axi_wr

    // axi4-lite read: returns data and response
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge CLK); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge CLK); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // print counts and verdict, end the run
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        give_verdict();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        chk("piston", 1, pist);
        chk("shift", 1, sm);
        axi_wr(8'h00, 32'h0014_0203); // top note 20, highest piston 3, highest level 2
        axi_rd(8'h20, d, r);
        chk("unmapped resp", 2, r);
        rem.push(UP, TAP);
        chk("piston idle", 1, pist);
        rem.push(PST, TAP);
        chk("seq on", 1, seq);
        p = 1;
        l = 1;
        for (int i = 0; i < 6; i++) begin
            rem.push(UP, TAP);
            if (p == 3) l = l % 2 + 1;
            p = p % 3 + 1;
            chk("piston up", p, pist);
            chk("level up", l, lvl);
        end
        rem.push(DN, TAP);
        chk("piston dn", 3, pist);
        chk("level dn", 2, lvl);
        rem.push(DN, TAP);
        chk("piston dn2", 2, pist);
        rem.push(PST, LONG);
        chk("piston hold", 1, pist);
        chk("level hold", 1, lvl);
        rem.push(PST, TAP);
        chk("seq off", 0, seq);
        rem.push(RFN, TAP);
        chk("ref on", 1, non);
        ref_n = 0;
        for (int i = 0; i < 4; i++) begin
            rem.push(UP, TAP);
            ref_n += stp[i];
            chk("ref step", ref_n, rn);
            rem.push(SHF, TAP);
            chk("shift cycle", oh[(i + 1) % 4], sm);
        end
        rem.push(TNN, TAP);
        chk("both on", 3, non);
        rem.push(UP, TAP);
        chk("ref both", 20, rn);
        chk("tune both", 1, tn);
        rem.push(RFN, LONG);
        chk("ref low c", 0, rn);
        chk("ref held on", 3, non);
        rem.push(DN, TAP);
        chk("ref floor", 0, rn);
        chk("tune down", 0, tn);
        rem.push(SHF, TAP);
        rem.push(SHF, LONG);
        chk("shift hold", 1, sm);
        axi_wr(8'h04, 32'h0000_0005); // boards 0 and 2 installed
        axi_rd(8'h04, d, r);
        chk("mask read", 5, d);
        rem.push(RFD, TAP);
        chk("ref div mode", 1, dmode);
        rem.push(UP, TAP);
        chk("ref div up", 2, rd);
        rem.push(UP, TAP);
        chk("ref div wrap", 0, rd);
        rem.push(UP, TAP);
        rem.push(RFD, LONG);
        chk("ref div hold", 0, rd);
        chk("ref div held on", 1, dmode);
        rem.push(RFD, TAP);
        chk("ref div off", 0, dmode);
        rem.push(TND, LONG);
        chk("tune div mode", 2, dmode);
        chk("tune div low", 0, td);
        rem.push(DN, TAP);
        chk("tune div dn", 2, td);
        rem.push(TND, LONG);
        chk("tune div rehold", 0, td);
        // mid-run reset must bring the modes back to idle
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        chk("note on rst", 0, non);
        chk("div mode rst", 0, dmode);
        give_verdict();
    end
endmodule : remote_tuning_control_bench
